// ==== include/npf_pkg.sv ====
// Shared constants for the phase and frequency control section of the oscillator.
package npf_pkg;

  localparam int unsigned NPF_CMD_W   = 16;
  localparam int unsigned NPF_ACC_W   = 32;
  localparam int unsigned NPF_PHASE_W = 16;
  localparam int unsigned NPF_KEY_W   = 2;

  // Holding register select codes.
  localparam logic [1:0] NPF_SEL_FREQ_LO = 2'h0;
  localparam logic [1:0] NPF_SEL_FREQ_HI = 2'h1;
  localparam logic [1:0] NPF_SEL_PHASE   = 2'h2;

  // Keying pair to top two phase bits: 0, 90, 270 and 180 degrees.
  localparam logic [1:0] NPF_KEY_0   = 2'h0;
  localparam logic [1:0] NPF_KEY_90  = 2'h1;
  localparam logic [1:0] NPF_KEY_180 = 2'h2;
  localparam logic [1:0] NPF_KEY_270 = 2'h3;

  // Reset values.
  localparam logic [31:0] NPF_ACC_RST    = 32'h0000_0000;
  localparam logic [15:0] NPF_WORD_RST   = 16'h0000;
  localparam logic        NPF_EN_N_RST   = 1'h1;
  localparam logic        NPF_PIN_N_RST  = 1'h1;

  // Position of the top bit of the argument, cleared in half-circle mode.
  localparam int unsigned NPF_ARG_MSB = 31;

  // Clock period in nanoseconds, for the host's tick increment arithmetic.
  localparam int unsigned NPF_CLK_PERIOD_NS = 40;

endpackage

// ==== core/npf_accum.sv ====
// Modulo accumulator with feedback gate and registered overflow bit.
`timescale 1ns/1ps
module npf_accum
  import npf_pkg::*;
#(
  parameter int unsigned W = NPF_ACC_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_inc,
  input  wire logic         i_feedback_en,
  output logic      [W-1:0] o_sum,
  output logic              o_carry
);

  logic [W-1:0] feedback;
  logic [W:0]   next_sum;

  assign feedback = i_feedback_en ? o_sum : '0;
  assign next_sum = {1'h0, feedback} + {1'h0, i_inc};

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sum   <= '0;
      o_carry <= 1'h0;
    end else begin
      o_sum   <= next_sum[W-1:0];
      o_carry <= next_sum[W];
    end
  end

endmodule // npf_accum

// ==== core/npf_holding.sv ====
// Input holding registers written from the command bus.
`timescale 1ns/1ps
module npf_holding
  import npf_pkg::*;
#(
  parameter int unsigned W = NPF_CMD_W
) (
  input  wire logic           i_clk,
  input  wire logic           i_rst_b,
  input  wire logic [W-1:0]   i_command_bus,
  input  wire logic [1:0]     i_holding_reg_select,
  input  wire logic           i_cs_n,
  input  wire logic           i_wr_n,
  output logic      [2*W-1:0] o_freq_word,
  output logic      [W-1:0]   o_phase_word
);

  logic [W-1:0] freq_lo;
  logic [W-1:0] freq_hi;
  wire          write_act;
  wire          wr_lo;
  wire          wr_hi;
  wire          wr_ph;

  assign write_act = !i_cs_n && !i_wr_n;
  assign wr_lo = write_act && (i_holding_reg_select == NPF_SEL_FREQ_LO);
  assign wr_hi = write_act && (i_holding_reg_select == NPF_SEL_FREQ_HI);
  assign wr_ph = write_act && (i_holding_reg_select == NPF_SEL_PHASE);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      freq_lo      <= '0;
      freq_hi      <= '0;
      o_phase_word <= '0;
    end else begin
      if (wr_lo) begin
        freq_lo <= i_command_bus;
      end
      if (wr_hi) begin
        freq_hi <= i_command_bus;
      end
      if (wr_ph) begin
        o_phase_word <= i_command_bus;
      end
    end
  end

  assign o_freq_word = {freq_hi, freq_lo};

endmodule // npf_holding

// ==== core/npf_pfc.sv ====
// Phase and frequency control section: holding registers, frequency registers, phase and time accumulators.
`timescale 1ns/1ps
module npf_pfc
  import npf_pkg::*;
#(
  parameter int unsigned CMD_W   = NPF_CMD_W,
  parameter int unsigned ACC_W   = NPF_ACC_W,
  parameter int unsigned PHASE_W = NPF_PHASE_W
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic [CMD_W-1:0]   i_command_bus,
  input  wire logic [1:0]         i_holding_reg_select,
  input  wire logic               i_cs_n,
  input  wire logic               i_wr_n,
  input  wire logic               i_center_freq_load_en_n,
  input  wire logic               i_offset_freq_load_en_n,
  input  wire logic               i_phase_load_en_n,
  input  wire logic               i_time_inc_load_en_n,
  input  wire logic               i_phase_source_select,
  input  wire logic [NPF_KEY_W-1:0] i_quad_keying_bits,
  input  wire logic               i_offset_disable_n,
  input  wire logic               i_accum_preset_n,
  input  wire logic               i_phase_range_select,
  input  wire logic               i_time_accum_clear_n,
  output logic      [ACC_W-1:0]   o_phase_arg,
  output logic                    o_phase_carry_out_n,
  output logic                    o_time_tick_n
);

  // Holding register contents.
  wire [2*CMD_W-1:0] freq_word;
  wire [CMD_W-1:0]   phase_word;

  // Registered load enables, all active low.
  logic center_freq_load_en_q_n;
  logic offset_freq_load_en_q_n;
  logic phase_load_en_q_n;

  // Frequency, phase and time increment registers.
  logic [ACC_W-1:0]   center_freq;
  logic [ACC_W-1:0]   offset_freq;
  logic [PHASE_W-1:0] phase_reg;
  logic [ACC_W-1:0]   time_inc;

  // Accumulator results.
  wire [ACC_W-1:0] phase_acc;
  wire             phase_ovf;
  wire [ACC_W-1:0] time_acc;
  wire             time_ovf;

  // Combinational terms.
  wire [ACC_W-1:0]   offset_term;
  wire [ACC_W-1:0]   phase_inc;
  wire [1:0]         key_top;
  wire [PHASE_W-1:0] keyed_phase;
  wire [PHASE_W-1:0] next_phase_reg;
  wire [PHASE_W-1:0] acc_top;
  wire [PHASE_W-1:0] arg_top;
  wire [ACC_W-1:0]   arg_full;
  wire [ACC_W-1:0]   next_phase_arg;
  wire               half_circle;

  npf_holding #(
    .W (CMD_W)
  ) u_holding (
    .i_clk                (i_clk),
    .i_rst_b              (i_rst_b),
    .i_command_bus        (i_command_bus),
    .i_holding_reg_select (i_holding_reg_select),
    .i_cs_n               (i_cs_n),
    .i_wr_n               (i_wr_n),
    .o_freq_word          (freq_word),
    .o_phase_word         (phase_word)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      center_freq_load_en_q_n <= NPF_EN_N_RST;
      offset_freq_load_en_q_n <= NPF_EN_N_RST;
      phase_load_en_q_n       <= NPF_EN_N_RST;
    end else begin
      center_freq_load_en_q_n <= i_center_freq_load_en_n;
      offset_freq_load_en_q_n <= i_offset_freq_load_en_n;
      phase_load_en_q_n       <= i_phase_load_en_n;
    end
  end

  // The registers keep reloading while the registered enable stays low, so a host that changes the
  // holding word during a long enable sees the new word take effect one clock later.
  // Center reload.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      center_freq <= NPF_ACC_RST;
    end else if (!center_freq_load_en_q_n) begin
      center_freq <= freq_word[ACC_W-1:0];
    end
  end

  // Offset frequency loads the same way as the center frequency.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      offset_freq <= NPF_ACC_RST;
    end else if (!offset_freq_load_en_q_n) begin
      offset_freq <= freq_word[ACC_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      time_inc <= NPF_ACC_RST;
    end else if (!i_time_inc_load_en_n) begin
      time_inc <= freq_word[ACC_W-1:0];
    end
  end

  assign key_top = (i_quad_keying_bits == 2'h0) ? NPF_KEY_0   :
                   (i_quad_keying_bits == 2'h1) ? NPF_KEY_90  :
                   (i_quad_keying_bits == 2'h2) ? NPF_KEY_270 :
                                                  NPF_KEY_180;
  assign keyed_phase = {key_top, {(PHASE_W-NPF_KEY_W){1'h0}}};
  assign next_phase_reg = i_phase_source_select ? keyed_phase : phase_word;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_reg <= NPF_WORD_RST;
    end else if (!phase_load_en_q_n) begin
      phase_reg <= next_phase_reg;
    end
  end

  assign offset_term = i_offset_disable_n ? offset_freq : '0;
  assign phase_inc = center_freq + offset_term;

  npf_accum #(
    .W (ACC_W)
  ) u_phase_acc (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_inc         (phase_inc),
    .i_feedback_en (i_accum_preset_n),
    .o_sum         (phase_acc),
    .o_carry       (phase_ovf)
  );

  npf_accum #(
    .W (ACC_W)
  ) u_time_acc (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_inc         (time_inc),
    .i_feedback_en (i_time_accum_clear_n),
    .o_sum         (time_acc),
    .o_carry       (time_ovf)
  );

  assign acc_top  = phase_acc[ACC_W-1 -: PHASE_W];
  assign arg_top  = acc_top + phase_reg;
  assign arg_full = {arg_top, phase_acc[ACC_W-PHASE_W-1:0]};

  assign half_circle = i_phase_range_select;
  assign next_phase_arg = half_circle ? {1'h0, arg_full[NPF_ARG_MSB-1:0]} : arg_full;

  // The argument is registered so that the sine stage sees a clean word; zero maps to 0 degrees and
  // counts advance counterclockwise, which the time accumulator contents do not affect.
  // Argument register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_phase_arg <= NPF_ACC_RST;
    end else begin
      o_phase_arg <= next_phase_arg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_phase_carry_out_n <= NPF_PIN_N_RST;
      o_time_tick_n       <= NPF_PIN_N_RST;
    end else begin
      o_phase_carry_out_n <= ~phase_ovf;
      o_time_tick_n       <= ~(time_ovf && i_time_accum_clear_n);
    end
  end

  // Time accumulator contents are only observable through the tick.
  wire unused_time_acc;
  assign unused_time_acc = ^time_acc;

endmodule // npf_pfc

// ==== bench/npf_pfc_sva.sv ====
// Port-level assertions for the phase and frequency control section.
`timescale 1ns/1ps
module npf_pfc_sva
  import npf_pkg::*;
#(
  parameter int unsigned ACC_W = NPF_ACC_W
) (
  input wire logic             i_clk,
  input wire logic             i_rst_b,
  input wire logic             i_center_freq_load_en_n,
  input wire logic             i_offset_freq_load_en_n,
  input wire logic             i_phase_load_en_n,
  input wire logic             i_phase_source_select,
  input wire logic             i_offset_disable_n,
  input wire logic             i_accum_preset_n,
  input wire logic             i_phase_range_select,
  input wire logic             i_time_accum_clear_n,
  input wire logic [ACC_W-1:0] o_phase_arg,
  input wire logic             o_phase_carry_out_n,
  input wire logic             o_time_tick_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // No frequency or phase register loads while all registered enables are parked high.
  wire frz = i_center_freq_load_en_n && i_offset_freq_load_en_n && i_phase_load_en_n;

  a_reset_idle: assert property ($rose(i_rst_b) |->
    (o_phase_arg == '0 && o_phase_carry_out_n && o_time_tick_n) [*2])
    else $error("outputs not idle after reset");
  a_half_circle_msb: assert property (i_phase_range_select |=> !o_phase_arg[NPF_ARG_MSB])
    else $error("argument top bit set in half-circle mode");
  a_preset_no_carry: assert property (!i_accum_preset_n |-> ##2 o_phase_carry_out_n)
    else $error("carry after preset");
  a_clear_no_tick: assert property (!i_time_accum_clear_n |-> ##2 o_time_tick_n)
    else $error("tick while time accumulator cleared");
  a_tick_has_cause: assert property (!o_time_tick_n |-> $past(i_time_accum_clear_n, 2))
    else $error("tick without running time accumulator");
  a_preset_hold: assert property ((!i_accum_preset_n && frz && $stable(i_offset_disable_n)
    && $stable(i_phase_range_select)) [*5] |-> $stable(o_phase_arg)) else $error("argument moved under preset");
  a_const_step: assert property ((i_accum_preset_n && frz && $stable(i_offset_disable_n)) [*5] |->
    31'(o_phase_arg - $past(o_phase_arg)) == 31'($past(o_phase_arg) - $past(o_phase_arg, 2)))
    else $error("phase step not constant");
  a_key_low_bits: assert property ((!i_accum_preset_n && i_phase_source_select && !i_phase_load_en_n
    && i_center_freq_load_en_n && i_offset_freq_load_en_n && $stable(i_offset_disable_n)) [*5]
    |-> $stable(o_phase_arg[29:0])) else $error("keying touched low argument bits");
endmodule // npf_pfc_sva

bind npf_pfc npf_pfc_sva #(.ACC_W(ACC_W)) npf_pfc_sva_inst (.*);

// ==== bench/npf_host.sv ====
// Host model that writes command words into the holding registers.
`timescale 1ns/1ps
module npf_host
  import npf_pkg::*;
(
  output logic [NPF_CMD_W-1:0] o_command_bus,
  output logic [1:0]           o_holding_reg_select,
  output logic                 o_cs_n,
  output logic                 o_wr_n
);
  logic [NPF_CMD_W-1:0] last_word = 16'h0000;
  initial begin
    o_command_bus = 16'hffff;
    o_holding_reg_select = 2'h3;
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
  end
  task automatic put(input logic [1:0] sel, input logic [15:0] data, input logic cs_n, input logic wr_n);
    o_holding_reg_select = sel;
    o_cs_n = cs_n;
    o_wr_n = wr_n;
    if (!cs_n && !wr_n) last_word = data;
    // An unqualified bus shows the inverse of the last word, so a stray capture cannot match by luck.
    o_command_bus = (!cs_n && !wr_n) ? data : ~last_word;
  endtask
  function automatic logic [31:0] tick_inc(input longint interval_ns);
    return 32'((64'h1_0000_0000 * NPF_CLK_PERIOD_NS) / interval_ns);
  endfunction
endmodule // npf_host

// ==== bench/npf_pfc_bench.sv ====
// Self-checking bench comparing the control section with a cycle model.
`timescale 1ns/1ps
module npf_pfc_bench
  import npf_pkg::*;
;
  logic i_clk = 0, i_rst_b = 0, cen_n = 1, oen_n = 1, pen_n = 1, ten_n = 1, pss = 0;
  logic offd_n = 1, pre_n = 1, rng = 0, clr_n = 1, cs_n, wr_n, carry_n, tick_n;
  logic [1:0] key = 2'h0, sel;
  logic [15:0] cmd, hl = 0, hh = 0, hp = 0, ph = 0;
  logic [31:0] arg, cf = 0, of = 0, tinc = 0, pacc = 0, tacc = 0, m_arg = 0, ti;
  logic cq = 1, oq = 1, pq = 1, pc = 0, tc = 0, m_pcn = 1, m_tkn = 1, m_tkx = 0;
  int miscompares = 0, total_checks = 0, cycles = 0;

  npf_host npf_host_inst (.o_command_bus(cmd), .o_holding_reg_select(sel), .o_cs_n(cs_n), .o_wr_n(wr_n));
  npf_pfc npf_pfc_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_command_bus(cmd), .i_holding_reg_select(sel),
    .i_cs_n(cs_n), .i_wr_n(wr_n), .i_center_freq_load_en_n(cen_n), .i_offset_freq_load_en_n(oen_n),
    .i_phase_load_en_n(pen_n), .i_time_inc_load_en_n(ten_n), .i_phase_source_select(pss),
    .i_quad_keying_bits(key), .i_offset_disable_n(offd_n), .i_accum_preset_n(pre_n),
    .i_phase_range_select(rng), .i_time_accum_clear_n(clr_n), .o_phase_arg(arg),
    .o_phase_carry_out_n(carry_n), .o_time_tick_n(tick_n));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin : model
    logic [32:0] ps, ts;
    logic [31:0] inc;
    if (!i_rst_b) begin
      {hl, hh, hp, ph, cf, of, tinc, pacc, tacc, m_arg, pc, tc} = '0;
      {cq, oq, pq, m_pcn, m_tkn} = '1;
    end else begin
      m_arg = pacc + {ph, 16'h0000};
      if (rng) m_arg[31] = 1'b0;
      m_pcn = !pc;
      m_tkn = !tc;
      // The tick alone is left unchecked on every cycle that samples clear low, since the forced level there is a design choice.
      m_tkx = !clr_n;
      inc = cf + (offd_n ? of : 32'h0);
      ps = 33'(pre_n ? pacc : 32'h0) + 33'(inc);
      {pc, pacc} = ps;
      ts = 33'(clr_n ? tacc : 32'h0) + 33'(tinc);
      {tc, tacc} = ts;
      if (!ten_n) tinc = {hh, hl};
      if (!cq) cf = {hh, hl};
      if (!oq) of = {hh, hl};
      if (!pq) ph = pss ? {key[1], key[1] ^ key[0], 14'h0000} : hp;
      {cq, oq, pq} = {cen_n, oen_n, pen_n};
      if (!cs_n && !wr_n && sel == 2'h0) hl = cmd;
      if (!cs_n && !wr_n && sel == 2'h1) hh = cmd;
      if (!cs_n && !wr_n && sel == 2'h2) hp = cmd;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Mode 0 is free random, 1 holds preset, 2 free-runs quietly, 3 keys the phase.
  task automatic step(input int mode);
    @(negedge i_clk);
    if (i_rst_b) begin
      check(arg, m_arg);
      check(32'(carry_n), 32'(m_pcn));
      if (!m_tkx) check(32'(tick_n), 32'(m_tkn));
    end
    npf_host_inst.put(2'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
    cen_n = mode != 0 || $urandom % 4 != 0;
    oen_n = mode != 0 || $urandom % 4 != 0;
    pen_n = mode != 3 && (mode != 0 || $urandom % 4 != 0);
    ten_n = mode != 0 || $urandom % 4 != 0;
    pre_n = (mode == 0) ? ($urandom % 8 != 0) : (mode == 2);
    pss = mode == 3 || (mode == 0 && 1'($urandom));
    offd_n = (mode == 0) ? 1'($urandom) : offd_n;
    key = 2'($urandom);
    rng = 1'($urandom);
    clr_n = $urandom % 8 != 0;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'hbe479fcf));
    repeat (5) @(negedge i_clk);
    i_rst_b = 1;
    ti = npf_host_inst.tick_inc(80);
    npf_host_inst.put(NPF_SEL_FREQ_LO, ti[15:0], 1'h0, 1'h0);
    @(negedge i_clk);
    npf_host_inst.put(NPF_SEL_FREQ_HI, ti[31:16], 1'h0, 1'h0);
    @(negedge i_clk);
    ten_n = 0;
    repeat (30) step(2);
    for (int blk = 0; blk < 150; blk++) begin
      if (blk == 75) begin
        i_rst_b = 0;
        repeat (2) @(negedge i_clk);
        i_rst_b = 1;
      end
      repeat (16) step(int'($urandom % 4));
    end
    stop_test();
  end
endmodule // npf_pfc_bench
